// ---- src/smc_pkg.sv ----
// Constants, field layouts and carrier types of the serializer mode and clock config bank
package smc_pkg;

   localparam logic [7:0] SMC_ADDR_MODE = 8'h03;
   localparam logic [7:0] SMC_ADDR_BC = 8'h04;
   localparam logic [7:0] SMC_ADDR_CLK = 8'h05;

   // Operating mode select layout
   localparam int SMC_RSV7_BIT = 7;
   localparam int SMC_STRAP6_BIT = 6;
   localparam int SMC_RSV5_BIT = 5;
   localparam int SMC_OVR_BIT = 4;
   localparam int SMC_DONE_BIT = 3;
   localparam int SMC_MODE_LSB = 0;
   localparam int SMC_MODE_W = 3;

   // Backchannel video mode select layout
   localparam int SMC_RAW10_BIT = 2;
   localparam int SMC_RAW12_BIT = 1;
   localparam int SMC_BLOCK_BIT = 0;

   // Reference clock control layout
   localparam int SMC_DIV_LSB = 4;
   localparam int SMC_DIV_W = 3;
   localparam int SMC_OSC_BIT = 3;

   // Reset values
   localparam logic SMC_RSV7_RST = 1'b0;
   localparam logic SMC_RSV5_RST = 1'b0;
   localparam logic SMC_OVR_RST = 1'b0;
   localparam logic SMC_DONE_RST = 1'b0;
   localparam logic [7:0] SMC_BC_RST = 8'h00;
   localparam logic [7:0] SMC_CLK_RST = 8'h03;

   // Mode codes
   localparam logic [2:0] SMC_MODE_CSI_SYNC = 3'h0;
   localparam logic [2:0] SMC_MODE_RSVD = 3'h1;
   localparam logic [2:0] SMC_MODE_CSI_EXT = 3'h2;
   localparam logic [2:0] SMC_MODE_CSI_AON = 3'h3;
   localparam logic [2:0] SMC_MODE_PAR_EXT = 3'h5;

   // Reference divider codes and ratios
   localparam logic [2:0] SMC_DIV1 = 3'h0;
   localparam logic [2:0] SMC_DIV2 = 3'h1;
   localparam logic [2:0] SMC_DIV4 = 3'h2;
   localparam logic [2:0] SMC_DIV8 = 3'h3;
   localparam logic [3:0] SMC_RATIO1 = 4'h1;
   localparam logic [3:0] SMC_RATIO2 = 4'h2;
   localparam logic [3:0] SMC_RATIO4 = 4'h4;
   localparam logic [3:0] SMC_RATIO8 = 4'h8;

   typedef struct packed {
      logic wr;
      logic rd;
      logic remote;
      logic [7:0] addr;
      logic [7:0] wdata;
   } smc_reg_req_t;

   typedef struct packed {
      logic csi_sync;
      logic csi_nonsync_ext;
      logic csi_nonsync_aon;
      logic parallel_ext;
      logic reserved;
   } smc_mode_dec_t;

   typedef struct packed {
      logic pdb_q;
      logic [2:0] strap_mode;
      logic strap_b6;
      logic mode_done;
      logic mode_override;
      logic [2:0] reg_mode;
      logic rsv7;
      logic rsv5;
      logic [7:0] bc_reg;
      logic [7:0] clk_reg;
      logic [2:0] eff_mode;
      smc_mode_dec_t dec;
      logic [3:0] div_ratio;
      logic div_rsvd;
      logic [7:0] rdata;
      logic rvalid;
   } smc_state_t;

endpackage

// ---- src/smc_config_regs.sv ----
// Mode, backchannel video mode and reference clock configuration registers
module smc_config_regs
   import smc_pkg::*;
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire smc_reg_req_t REQ_I,
   input wire logic LCL_WR_DIS_I,
   input wire logic POWER_DOWN_BAR_I,
   input wire logic [2:0] STRAP_MODE_I,
   input wire logic STRAP_RSVD_I,
   input wire logic RX_LOCK_I,
   input wire logic BC_LOAD_I,
   input wire logic BC_RAW10_I,
   input wire logic BC_RAW12_I,
   output logic [7:0] RDATA_O,
   output logic RVALID_O,
   output logic [2:0] MODE_O,
   output smc_mode_dec_t MODE_DEC_O,
   output logic MODE_DONE_O,
   output logic RAW10_PARALLEL_SELECT_O,
   output logic RAW12_PARALLEL_SELECT_O,
   output logic [3:0] REF_DIV_RATIO_O,
   output logic REF_DIV_RSVD_O,
   output logic OSC_RANGE_HI_O
);

   smc_state_t s;
   smc_state_t next_s;
   logic wr_ok;
   logic hit_mode;
   logic hit_bc;
   logic pdb_rise;
   logic [2:0] wr_mode;

   // Remote writes are dropped when local write protection is on
   assign wr_ok = REQ_I.wr && !(REQ_I.remote && LCL_WR_DIS_I);
   assign hit_mode = wr_ok && (REQ_I.addr == SMC_ADDR_MODE);
   assign hit_bc = wr_ok && (REQ_I.addr == SMC_ADDR_BC);
   assign pdb_rise = POWER_DOWN_BAR_I && !s.pdb_q;
   assign wr_mode = REQ_I.wdata[SMC_MODE_LSB +: SMC_MODE_W];

   always_comb begin
      next_s = s;
      next_s.rvalid = 1'b0;
      next_s.pdb_q = POWER_DOWN_BAR_I;

      // Strap sampled on the release edge; done drops while held in power-down
      if (pdb_rise) begin
         next_s.strap_mode = STRAP_MODE_I;
         next_s.strap_b6 = STRAP_RSVD_I;
         next_s.mode_done = 1'b1;
      end else if (!POWER_DOWN_BAR_I) begin
         next_s.mode_done = 1'b0;
      end

      if (wr_ok) begin
         unique case (REQ_I.addr)
            SMC_ADDR_MODE: begin
               next_s.rsv7 = REQ_I.wdata[SMC_RSV7_BIT];
               next_s.rsv5 = REQ_I.wdata[SMC_RSV5_BIT];
               next_s.mode_override = REQ_I.wdata[SMC_OVR_BIT];
               // Mode field only accepted together with the override bit
               if (REQ_I.wdata[SMC_OVR_BIT]) begin
                  next_s.reg_mode = wr_mode;
               end
            end
            SMC_ADDR_BC: begin
               next_s.bc_reg = REQ_I.wdata;
            end
            SMC_ADDR_CLK: begin
               next_s.clk_reg = REQ_I.wdata;
            end
            default: begin
            end
         endcase
      end

      // Control channel load wins over a same-cycle write when RX is locked, unless blocked
      if (BC_LOAD_I && RX_LOCK_I && !next_s.bc_reg[SMC_BLOCK_BIT]) begin
         next_s.bc_reg[SMC_RAW10_BIT] = BC_RAW10_I;
         next_s.bc_reg[SMC_RAW12_BIT] = BC_RAW12_I;
      end

      next_s.eff_mode = next_s.mode_override ? next_s.reg_mode : next_s.strap_mode;

      next_s.dec = '0;
      unique case (next_s.eff_mode)
         SMC_MODE_CSI_SYNC: next_s.dec.csi_sync = 1'b1;
         SMC_MODE_CSI_EXT: next_s.dec.csi_nonsync_ext = 1'b1;
         SMC_MODE_CSI_AON: next_s.dec.csi_nonsync_aon = 1'b1;
         SMC_MODE_PAR_EXT: next_s.dec.parallel_ext = 1'b1;
         default: next_s.dec.reserved = 1'b1;
      endcase

      // Reserved divider codes give no ratio rather than a guess
      next_s.div_rsvd = 1'b0;
      unique case (next_s.clk_reg[SMC_DIV_LSB +: SMC_DIV_W])
         SMC_DIV1: next_s.div_ratio = SMC_RATIO1;
         SMC_DIV2: next_s.div_ratio = SMC_RATIO2;
         SMC_DIV4: next_s.div_ratio = SMC_RATIO4;
         SMC_DIV8: next_s.div_ratio = SMC_RATIO8;
         default: begin
            next_s.div_ratio = 4'h0;
            next_s.div_rsvd = 1'b1;
         end
      endcase

      if (REQ_I.rd) begin
         next_s.rvalid = 1'b1;
         unique case (REQ_I.addr)
            SMC_ADDR_MODE: next_s.rdata = {s.rsv7, s.strap_b6, s.rsv5, s.mode_override,
                                            s.mode_done, s.eff_mode};
            SMC_ADDR_BC: next_s.rdata = s.bc_reg;
            SMC_ADDR_CLK: next_s.rdata = s.clk_reg;
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         s <= '0;
         s.rsv7 <= SMC_RSV7_RST;
         s.rsv5 <= SMC_RSV5_RST;
         s.mode_override <= SMC_OVR_RST;
         s.mode_done <= SMC_DONE_RST;
         s.bc_reg <= SMC_BC_RST;
         s.clk_reg <= SMC_CLK_RST;
         s.eff_mode <= SMC_MODE_CSI_SYNC;
         s.dec.csi_sync <= 1'b1;
         s.div_ratio <= SMC_RATIO1;
      end else if (CE_I) begin
         s <= next_s;
      end
   end

   assign RDATA_O = s.rdata;
   assign RVALID_O = s.rvalid;
   assign MODE_O = s.eff_mode;
   assign MODE_DEC_O = s.dec;
   assign MODE_DONE_O = s.mode_done;
   assign RAW10_PARALLEL_SELECT_O = s.bc_reg[SMC_RAW10_BIT];
   assign RAW12_PARALLEL_SELECT_O = s.bc_reg[SMC_RAW12_BIT];
   assign REF_DIV_RATIO_O = s.div_ratio;
   assign REF_DIV_RSVD_O = s.div_rsvd;
   assign OSC_RANGE_HI_O = s.clk_reg[SMC_OSC_BIT];

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);

   a_ovr_clear_strap: assert property (!s.mode_override |-> MODE_O == s.strap_mode)
      else $error("mode differs from strap with override clear");
   a_ovr_set_reg: assert property (s.mode_override |-> MODE_O == s.reg_mode)
      else $error("mode differs from register with override set");
   a_pdb_capture: assert property (CE_I && pdb_rise |=> MODE_DONE_O && s.strap_mode == $past(STRAP_MODE_I))
      else $error("strap not captured on power-down release");
   a_done_drop: assert property (CE_I && !POWER_DOWN_BAR_I |=> !MODE_DONE_O)
      else $error("mode done set during power-down");
   a_mode_write: assert property (CE_I && hit_mode && REQ_I.wdata[SMC_OVR_BIT] |=> MODE_O == $past(wr_mode))
      else $error("written mode not in effect");
   a_mode_ignore: assert property (CE_I && hit_mode && !REQ_I.wdata[SMC_OVR_BIT] && !pdb_rise
                                   |=> MODE_O == $past(s.strap_mode))
      else $error("mode write accepted without override");
   a_mode_decode: assert property ((MODE_O == SMC_MODE_PAR_EXT) == MODE_DEC_O.parallel_ext
                                   && (MODE_O == SMC_MODE_CSI_AON) == MODE_DEC_O.csi_nonsync_aon)
      else $error("mode decode mismatch");
   a_auto_load: assert property (CE_I && BC_LOAD_I && RX_LOCK_I && !s.bc_reg[SMC_BLOCK_BIT] && !hit_bc
                                 |=> RAW10_PARALLEL_SELECT_O == $past(BC_RAW10_I)
                                 && RAW12_PARALLEL_SELECT_O == $past(BC_RAW12_I))
      else $error("control channel load not applied");
   a_load_block: assert property (CE_I && s.bc_reg[SMC_BLOCK_BIT] && !hit_bc
                                  |=> $stable(RAW10_PARALLEL_SELECT_O) && $stable(RAW12_PARALLEL_SELECT_O))
      else $error("parallel bits changed while load blocked");
   a_div_ratio: assert property (s.clk_reg[SMC_DIV_LSB +: SMC_DIV_W] == SMC_DIV8 |-> REF_DIV_RATIO_O == SMC_RATIO8
                                 && !REF_DIV_RSVD_O)
      else $error("divide by eight not decoded");
   a_osc_range: assert property (CE_I && hit_bc == 1'b0 && wr_ok && REQ_I.addr == SMC_ADDR_CLK
                                 |=> OSC_RANGE_HI_O == $past(REQ_I.wdata[SMC_OSC_BIT]))
      else $error("oscillator range not taken from write");

endmodule

// ---- verif/smc_host_model.sv ----
// Behavioural register host and control channel facing the config bank
module smc_host_model
   import smc_pkg::*;
(
   input wire logic clk_i,
   output smc_reg_req_t req_o,
   output logic bc_load_o,
   output logic bc_raw10_o,
   output logic bc_raw12_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_o = '0;
      bc_load_o = 1'b0;
      bc_raw10_o = 1'b0;
      bc_raw12_o = 1'b0;
   end
   // Released address and data are inverted so stale values never look valid
   task automatic access(input logic w, input logic r, input logic rem, input logic [7:0] a, input logic [7:0] d);
      logic [7:0] dd;
      dd = (w && a == SMC_ADDR_BC && (|d[2:1])) ? (d | 8'h01) : d;
      @(posedge clk_i);
      req_o <= '{wr: w, rd: r, remote: rem, addr: a, wdata: dd};
      @(posedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b0, remote: 1'b0, addr: ~a, wdata: ~dd};
   endtask
   task automatic offer(input logic r10, input logic r12);
      @(posedge clk_i);
      bc_load_o <= 1'b1;
      bc_raw10_o <= r10;
      bc_raw12_o <= r12;
      @(posedge clk_i);
      bc_load_o <= 1'b0;
      bc_raw10_o <= ~r10;
      bc_raw12_o <= ~r12;
   endtask
endmodule

// ---- verif/serializer_mode_clock_config_bench.sv ----
// Self-checking bench of the mode and clock config bank against a reference model
module serializer_mode_clock_config_bench;
   import smc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, lcl_wr_dis, power_down_bar, rx_lock, bc_load, bc_r10, bc_r12, ce;
   logic rvalid, done, raw10, raw12, div_rsvd, osc, m_ovr, m_done;
   logic [2:0] strap, mode, m_strap, m_rmode;
   logic [3:0] ratio;
   logic [7:0] rdata, m_hi, m_bc, m_clk, d;
   logic [31:0] seed;
   smc_reg_req_t req;
   smc_mode_dec_t dec;
   int mismatches, compares;
   smc_host_model u_smc_host_model (.clk_i(clk), .req_o(req), .bc_load_o(bc_load), .bc_raw10_o(bc_r10),
      .bc_raw12_o(bc_r12));
   smc_config_regs u_smc_config_regs (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .REQ_I(req),
      .LCL_WR_DIS_I(lcl_wr_dis), .POWER_DOWN_BAR_I(power_down_bar), .STRAP_MODE_I(strap), .STRAP_RSVD_I(strap[0]),
      .RX_LOCK_I(rx_lock), .BC_LOAD_I(bc_load), .BC_RAW10_I(bc_r10), .BC_RAW12_I(bc_r12), .RDATA_O(rdata),
      .RVALID_O(rvalid), .MODE_O(mode), .MODE_DEC_O(dec), .MODE_DONE_O(done), .RAW10_PARALLEL_SELECT_O(raw10),
      .RAW12_PARALLEL_SELECT_O(raw12), .REF_DIV_RATIO_O(ratio), .REF_DIV_RSVD_O(div_rsvd), .OSC_RANGE_HI_O(osc));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [4:0] dec_of(input logic [2:0] m);
      return {m == 3'h0, m == 3'h2, m == 3'h3, m == 3'h5, !(m inside {3'h0, 3'h2, 3'h3, 3'h5})};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic outs();
      logic [2:0] m;
      m = m_ovr ? m_rmode : m_strap;
      chk({5'h0, mode}, {5'h0, m});
      chk({3'h0, dec}, {3'h0, dec_of(m)});
      chk({7'h0, done}, {7'h0, m_done});
      chk({6'h0, raw10, raw12}, {6'h0, m_bc[2:1]});
      chk({4'h0, ratio}, (m_clk[6:4] < 3'h4) ? 8'h1 << m_clk[6:4] : 8'h0);
      chk({6'h0, div_rsvd, osc}, {6'h0, m_clk[6], m_clk[3]});
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      u_smc_host_model.access(1'b0, 1'b1, 1'b0, a, 8'h00);
      #1;
      chk({7'h0, rvalid}, 8'h01);
      chk(rdata, exp);
   endtask
   task automatic regs();
      rd_chk(SMC_ADDR_MODE, {m_hi[7], m_strap[0], m_hi[5], m_ovr, m_done, m_ovr ? m_rmode : m_strap});
      rd_chk(SMC_ADDR_BC, m_bc);
      rd_chk(SMC_ADDR_CLK, m_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic rem);
      u_smc_host_model.access(1'b1, 1'b0, rem, a, v);
      #1;
      if (!(rem && lcl_wr_dis)) begin
         if (a == SMC_ADDR_MODE) begin
            m_ovr = v[4];
            m_hi = v & 8'ha0;
            if (v[4])
               m_rmode = v[2:0];
         end
         if (a == SMC_ADDR_BC)
            m_bc = v;
         if (a == SMC_ADDR_CLK)
            m_clk = v;
      end
      outs();
   endtask
   task automatic bc(input logic r10, input logic r12);
      u_smc_host_model.offer(r10, r12);
      #1;
      if (rx_lock && !m_bc[0])
         m_bc[2:1] = {r10, r12};
      outs();
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Whole run is a few hundred cycles
   initial begin
      #50000;
      mismatches++;
      summarize();
   end
   initial begin
      {rst_n, lcl_wr_dis, power_down_bar, rx_lock, strap, m_strap, m_rmode, m_ovr, m_done, m_hi, m_bc} = '0;
      ce = 1'b1;
      m_clk = 8'h03;
      seed = 32'he7a9290d;
      mismatches = 0;
      compares = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      outs();
      regs();
      rd_chk(8'h00, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         @(posedge clk);
         power_down_bar <= 1'b0;
         strap <= seed[2:0];
         @(posedge clk);
         #1;
         m_done = 1'b0;
         outs();
         @(posedge clk);
         power_down_bar <= 1'b1;
         strap <= i[2:0];
         @(posedge clk);
         strap <= seed[5:3];
         #1;
         m_strap = i[2:0];
         m_done = 1'b1;
         outs();
         regs();
      end
      $display("test strap done");
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         d = seed[7:0];
         d[4] = k[0];
         wr(SMC_ADDR_MODE, d, 1'b0);
         regs();
      end
      $display("test override done");
      for (int c = 0; c < 8; c++) begin
         seed = xs(seed);
         @(posedge clk);
         lcl_wr_dis <= seed[9];
         wr(SMC_ADDR_CLK, {seed[7], c[2:0], seed[3:0]}, seed[8]);
         regs();
      end
      $display("test clock done");
      // Enable low: a write must be lost and all state frozen
      @(posedge clk);
      ce <= 1'b0;
      u_smc_host_model.access(1'b1, 1'b0, 1'b0, SMC_ADDR_CLK, ~m_clk);
      #1;
      outs();
      @(posedge clk);
      ce <= 1'b1;
      regs();
      $display("test enable done");
      bc(1'b1, 1'b1);
      @(posedge clk);
      rx_lock <= 1'b1;
      bc(1'b1, 1'b0);
      bc(1'b0, 1'b1);
      wr(SMC_ADDR_BC, 8'h05, 1'b0);
      bc(1'b0, 1'b1);
      wr(SMC_ADDR_BC, 8'h00, 1'b0);
      bc(1'b1, 1'b1);
      regs();
      $display("test backchannel done");
      summarize();
   end
endmodule
